// >>> logic/dsd_standstill.sv
// Drive standstill detector: watches encoder edges after the
// drive enable falls and reports a confirmed stop.
// Assumes all inputs are synchronous to i_sys_clk and that
// i_tick pulses for one clock once per logic cycle.
//
// Overview of operation
// - Drive enable falling edge starts a detection run.
// - Standstill after quiet time without any edge.
// - Drive enable high clears standstill, aborts run.
// - Edges ignored while enabled or standstill.
// - Pair low two cycles raises wiring error.
// - Error clears when pair active, enable low.
// - Fault flag follows any wiring error.
// - Single input, one pair, or two pairs.
// - Plausibility check only with pair configurations.
// - Quiet time 100 ms to 10 s, 10 ms steps.
module dsd_standstill (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_tick,
  input  wire logic       i_drive_en,
  input  wire logic [3:0] i_enc,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_plaus_en,
  input  wire logic       i_fault_use,
  input  wire logic [9:0] i_quiet_steps,
  input  wire logic [7:0] i_cycle_ms,
  output logic            o_standstill,
  output logic [1:0]      o_wire_err,
  output logic            o_fault,
  output logic            o_cfg_err
);

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  logic [3:0]  ch_mask;   // Encoder channels in use.
  logic [1:0]  pair_use;  // Pairs in use.
  logic        plaus_ok;  // Check allowed and requested.
  logic [13:0] quiet_ms;  // Quiet time in milliseconds.
  logic        cfg_bad;   // Configuration out of range.

  // Decodes the input configuration and checks its ranges.
  always_comb begin
    unique case (i_mode)
      dsd_pkg::MODE_SINGLE: begin
        ch_mask  = dsd_pkg::MASK_SINGLE;
        pair_use = 2'h0;
      end
      dsd_pkg::MODE_PAIR1: begin
        ch_mask  = dsd_pkg::MASK_PAIR1;
        pair_use = 2'h1;
      end
      dsd_pkg::MODE_PAIR2: begin
        ch_mask  = dsd_pkg::MASK_PAIR2;
        pair_use = 2'h3;
      end
      default: begin
        // The fourth code is illegal and watches nothing.
        ch_mask  = 4'h0;
        pair_use = 2'h0;
      end
    endcase
    // The check never runs on a single channel.
    plaus_ok = i_plaus_en && (i_mode != dsd_pkg::MODE_SINGLE);
    quiet_ms = 14'(i_quiet_steps * dsd_pkg::STEP_MS);
    // Out-of-range values block the standstill report.
    cfg_bad  = (i_quiet_steps < dsd_pkg::QSTEP_MIN)
            || (i_quiet_steps > dsd_pkg::QSTEP_MAX)
            || (quiet_ms <= 14'(i_cycle_ms))
            || (i_mode == 2'h3)
            || (i_plaus_en && !plaus_ok);
  end

  // ----------------------------------------
  // Sampling and edge detection
  // ----------------------------------------
  logic [3:0] enc_ff;      // Encoder sample of last tick.
  logic [3:0] nxt_enc;
  logic       drv_ff;      // Drive enable of last tick.
  logic       nxt_drv;
  logic       first_ff;    // High until first tick seen.
  logic       nxt_first;
  logic       any_edge;    // Edge on a used channel.
  logic       drv_fall;    // Drive enable fell this tick.

  // Takes a new sample on every tick.
  always_comb begin
    nxt_enc   = enc_ff;
    nxt_drv   = drv_ff;
    nxt_first = first_ff;
    if (i_tick) begin
      nxt_enc   = i_enc;
      nxt_drv   = i_drive_en;
      nxt_first = 1'b0;
    end
    // No edge is seen on the very first sample.
    any_edge = i_tick && !first_ff && |((i_enc ^ enc_ff) & ch_mask);
    drv_fall = i_tick && !first_ff && drv_ff && !i_drive_en;
  end

  // Registers the samples.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      enc_ff   <= dsd_pkg::ENC_RST;
      drv_ff   <= 1'b0;
      first_ff <= 1'b1;
    end else begin
      enc_ff   <= nxt_enc;
      drv_ff   <= nxt_drv;
      first_ff <= nxt_first;
    end
  end

  // ----------------------------------------
  // Detection run
  // ----------------------------------------
  dsd_pkg::dsd_state_t state_ff;   // Run state.
  dsd_pkg::dsd_state_t nxt_state;
  logic [13:0] quiet_ff;           // Milliseconds without edge.
  logic [13:0] nxt_quiet;
  logic [13:0] quiet_sum;          // Count after this tick.
  logic        nxt_still;

  // Counts quiet logic cycles and decides the stop.
  always_comb begin
    nxt_state = state_ff;
    nxt_quiet = quiet_ff;
    quiet_sum = 14'(quiet_ff + 14'(i_cycle_ms));
    if (i_drive_en) begin
      // Running drive clears the report at once.
      nxt_state = dsd_dsd_run();
      nxt_quiet = dsd_pkg::MS_RST;
    end else begin
      unique case (state_ff)
        dsd_pkg::DSD_RUN: begin
          if (drv_fall && !cfg_bad) begin
            nxt_state = dsd_pkg::DSD_WATCH;
            nxt_quiet = dsd_pkg::MS_RST;
          end
        end
        dsd_pkg::DSD_WATCH: begin
          if (cfg_bad) begin
            nxt_state = dsd_pkg::DSD_RUN;
          end else if (any_edge) begin
            nxt_quiet = dsd_pkg::MS_RST;
          end else if (i_tick) begin
            nxt_quiet = quiet_sum;
            if (quiet_sum >= quiet_ms) begin
              nxt_state = dsd_pkg::DSD_STOP;
            end
          end
        end
        dsd_pkg::DSD_STOP: begin
          // Edges are no longer looked at here.
          nxt_state = dsd_pkg::DSD_STOP;
        end
      endcase
    end
    nxt_still = (nxt_state == dsd_pkg::DSD_STOP);
  end

  // Returns the running state code.
  function automatic dsd_pkg::dsd_state_t dsd_dsd_run();
    return dsd_pkg::DSD_RUN;
  endfunction

  // Registers the run state and the standstill output.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff     <= dsd_pkg::DSD_RUN;
      quiet_ff     <= dsd_pkg::MS_RST;
      o_standstill <= 1'b0;
      o_cfg_err    <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      quiet_ff     <= nxt_quiet;
      o_standstill <= nxt_still;
      o_cfg_err    <= cfg_bad;
    end
  end

  // ----------------------------------------
  // Pair plausibility check
  // ----------------------------------------
  logic [1:0] low_ff;     // Pair was all low last tick.
  logic [1:0] nxt_low;
  logic [1:0] pair_low;   // Pair all low now.
  logic [1:0] nxt_err;

  // One check per pair.
  for (genvar p = 0; p < dsd_pkg::PAIRS; p++) begin : g_pair
    // Works out the next error and low history of pair p.
    always_comb begin
      pair_low[p] = !i_enc[2*p] && !i_enc[2*p+1];
      nxt_low[p]  = low_ff[p];
      nxt_err[p]  = o_wire_err[p];
      if (!(plaus_ok && pair_use[p])) begin
        // An unused pair carries no error.
        nxt_low[p] = 1'b0;
        nxt_err[p] = 1'b0;
      end else if (i_tick) begin
        nxt_low[p] = pair_low[p];
        if (pair_low[p] && low_ff[p]) begin
          nxt_err[p] = 1'b1;
        end else if (!pair_low[p] && !i_drive_en) begin
          nxt_err[p] = 1'b0;
        end
      end
    end
  end

  // Registers the errors and the fault flag.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      low_ff     <= 2'h0;
      o_wire_err <= 2'h0;
      o_fault    <= 1'b0;
    end else begin
      low_ff     <= nxt_low;
      o_wire_err <= nxt_err;
      o_fault    <= i_fault_use && |nxt_err;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  // Enable high always clears the report next clock.
  a_enable_clears_out: assert property (
    i_drive_en |=> !o_standstill && state_ff == dsd_pkg::DSD_RUN)
    else $error("Standstill not cleared by drive enable.");

  // A falling enable with good setup starts a run.
  a_fall_starts_run: assert property (
    drv_fall && !cfg_bad && state_ff == dsd_pkg::DSD_RUN
    |=> state_ff == dsd_pkg::DSD_WATCH && quiet_ff == dsd_pkg::MS_RST)
    else $error("Falling enable did not start a run.");

  // Standstill only rises out of a run with enough quiet.
  a_stop_needs_quiet: assert property (
    $rose(o_standstill) |-> $past(state_ff) == dsd_pkg::DSD_WATCH
      && quiet_ff >= quiet_ms && $past(i_tick) && !$past(any_edge))
    else $error("Standstill rose without full quiet time.");

  // Once stopped, edges do not drop the report.
  a_stop_holds: assert property (
    o_standstill && !i_drive_en |=> o_standstill)
    else $error("Standstill dropped while drive disabled.");

  // Two low samples in a row raise the error.
  a_pair_low_err: assert property (
    i_tick && plaus_ok && pair_use[0] && pair_low[0] && low_ff[0]
    |=> o_wire_err[0])
    else $error("Wiring error not raised on pair 0.");

  // The error only falls with the pair active and drive off, or when the pair is not checked.
  a_err_clear_cond: assert property (
    $fell(o_wire_err[1]) |-> $past(!pair_low[1] && !i_drive_en)
      || !$past(plaus_ok && pair_use[1]))
    else $error("Wiring error cleared under wrong condition.");

  // The fault flag is high exactly while an error stands and the flag is in use.
  a_fault_tracks_err: assert property (
    o_fault == ((|o_wire_err) && $past(i_fault_use)))
    else $error("Fault flag does not follow wiring errors.");

  // An enabled drive keeps the quiet count at zero, so edges then do nothing.
  a_enabled_no_count: assert property (
    i_drive_en |=> quiet_ff == dsd_pkg::MS_RST)
    else $error("Quiet count moved while drive enabled.");

  // An edge seen on a watch tick restarts the quiet count.
  a_edge_restarts: assert property (
    i_tick && any_edge && state_ff == dsd_pkg::DSD_WATCH && !i_drive_en && !cfg_bad
    |=> quiet_ff == dsd_pkg::MS_RST)
    else $error("Edge did not restart the quiet count.");

  // Single channel mode never reports a wiring error.
  a_single_no_check: assert property (
    i_mode == dsd_pkg::MODE_SINGLE |=> o_wire_err == 2'h0)
    else $error("Wiring error in single channel mode.");

  // A too short quiet time is flagged.
  a_quiet_range: assert property (
    i_quiet_steps < dsd_pkg::QSTEP_MIN |=> o_cfg_err && !$rose(o_standstill))
    else $error("Quiet time below range not flagged.");

  // Without a tick the quiet count stands still.
  a_tick_paces: assert property (
    !i_tick && !i_drive_en && !cfg_bad |=> $stable(quiet_ff))
    else $error("Quiet count moved without a tick.");

  // Before the first tick standstill, wiring errors and fault stay low.
  a_quiet_start: assert property (
    first_ff |-> !o_standstill && o_wire_err == 2'h0 && !o_fault)
    else $error("Output high before first logic cycle.");

endmodule

// >>> logic/dsd_pkg.sv
// Shared constants and types for the drive standstill detector.
// Assumes one system clock and a logic-cycle tick from outside.
package dsd_pkg;

  // ----------------------------------------
  // Input configurations
  // ----------------------------------------
  // One single-channel encoder input.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  // One encoder input pair.
  localparam logic [1:0] MODE_PAIR1  = 2'h1;
  // Two encoder input pairs.
  localparam logic [1:0] MODE_PAIR2  = 2'h2;

  // ----------------------------------------
  // Field positions of the encoder bus
  // ----------------------------------------
  // Number of encoder wires and of pairs.
  localparam int ENC_W   = 4;
  localparam int PAIRS   = 2;
  // Channel masks for each configuration.
  localparam logic [3:0] MASK_SINGLE = 4'h1;
  localparam logic [3:0] MASK_PAIR1  = 4'h3;
  localparam logic [3:0] MASK_PAIR2  = 4'hF;

  // ----------------------------------------
  // Timing in milliseconds
  // ----------------------------------------
  // Quiet time limits and step, as printed.
  localparam int QUIET_MIN_MS  = 100;
  localparam int QUIET_MAX_MS  = 10000;
  localparam int QUIET_STEP_MS = 10;
  // Quiet time input limits in steps.
  localparam logic [9:0] QSTEP_MIN = 10'(QUIET_MIN_MS / QUIET_STEP_MS);
  localparam logic [9:0] QSTEP_MAX = 10'(QUIET_MAX_MS / QUIET_STEP_MS);
  // Width of the millisecond counters.
  localparam int MS_W = 14;
  // Step size at counter width.
  localparam logic [13:0] STEP_MS = 14'(QUIET_STEP_MS);

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [13:0] MS_RST  = 14'h0000;
  localparam logic [3:0]  ENC_RST = 4'h0;

  // ----------------------------------------
  // Detection state, Gray along the path
  // ----------------------------------------
  typedef enum logic [1:0] {
    DSD_RUN   = 2'b00,
    DSD_WATCH = 2'b01,
    DSD_STOP  = 2'b11
  } dsd_state_t;

endpackage

// >>> sim/dsd_enc_model.sv
// Encoder model: complementary wire pairs that move one tooth per step.
// Assumes i_step pulses for one clock between logic-cycle ticks.
module dsd_enc_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_step,
  input  wire logic [1:0] i_cut,
  output logic      [3:0] o_enc
);
  timeunit 1ns;
  timeprecision 1ps;

  logic phase_ff;   // Wheel position, shared by both pairs.
  logic nxt_phase;  // Position after this clock.

  // Next position advances one tooth per step request.
  always_comb begin
    nxt_phase = phase_ff ^ i_step;
  end

  // Position register.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_ff <= 1'h0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Each pair keeps one wire high; a cut pair reads low on both wires.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      o_enc[2*p]   = phase_ff & ~i_cut[p];
      o_enc[2*p+1] = ~phase_ff & ~i_cut[p];
    end
  end
endmodule

// >>> sim/dsd_standstill_tb_top.sv
// Self-checking bench for the standstill detector.
// Assumes one tick every four clocks and a 50 ms logic cycle.
module dsd_standstill_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, rstn, tick, den, plaus, fuse, step, ss, flt, cerr;
  logic [1:0] mode, cut, werr;
  logic [9:0] qs;
  logic [7:0] cms;
  logic [3:0] enc;
  int         mismatches, n_checks, cyc;

  dsd_enc_model i_enc (.i_sys_clk(clk), .i_rstn(rstn), .i_step(step), .i_cut(cut), .o_enc(enc));
  dsd_standstill i_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_tick(tick), .i_drive_en(den), .i_enc(enc),
    .i_mode(mode), .i_plaus_en(plaus), .i_fault_use(fuse), .i_quiet_steps(qs), .i_cycle_ms(cms),
    .o_standstill(ss), .o_wire_err(werr), .o_fault(flt), .o_cfg_err(cerr));

  // Compare tasks, one per kind of result.
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic chk_err(input logic [1:0] got, input logic [1:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Waits n edges and lands just after the last one.
  task automatic clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One logic cycle: a one-clock tick, then three idle clocks.
  task automatic do_tick;
    tick = 1'h1;
    clks(1);
    tick = 1'h0;
    clks(3);
  endtask
  // Moves the wheel by one tooth.
  task automatic do_step;
    step = 1'h1;
    clks(1);
    step = 1'h0;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Outputs stay low straight after reset.
  task automatic t_reset;
    chk_bit(ss, 1'h0, "standstill after reset");
    chk_err(werr, 2'h0, "wire error after reset");
    chk_bit(flt, 1'h0, "fault after reset");
    $display("t_reset done");
  endtask

  // Run with coasting edges, stop after two quiet cycles, then release.
  task automatic t_stop;
    den = 1'h1;
    do_tick();
    den = 1'h0;
    do_tick();
    repeat (2) begin
      do_step();
      do_tick();
    end
    do_tick();
    chk_bit(ss, 1'h0, "stop before quiet time");
    do_tick();
    chk_bit(ss, 1'h1, "no stop after quiet time");
    do_step();
    do_tick();
    chk_bit(ss, 1'h1, "edge cleared stop");
    den = 1'h1;
    clks(2);
    chk_bit(ss, 1'h0, "enable did not clear stop");
    $display("t_stop done");
  endtask

  // Enable in mid-run aborts the count; enabled edges are not watched.
  task automatic t_abort;
    den = 1'h1;
    do_tick();
    den = 1'h0;
    do_tick();
    do_tick();
    den = 1'h1;
    clks(1);
    den = 1'h0;
    do_tick();
    do_tick();
    chk_bit(ss, 1'h0, "run not aborted");
    den = 1'h1;
    do_step();
    do_tick();
    chk_bit(ss, 1'h0, "stop while enabled");
    $display("t_abort done");
  endtask

  // Pair cut for one and two cycles, clearing held while enabled.
  task automatic t_plaus;
    mode = dsd_pkg::MODE_PAIR1;
    plaus = 1'h1;
    fuse = 1'h1;
    cut = 2'h1;
    do_tick();
    cut = 2'h0;
    do_tick();
    chk_err(werr, 2'h0, "error after one low cycle");
    cut = 2'h1;
    do_tick();
    do_tick();
    chk_err(werr, 2'h1, "no error after two low cycles");
    chk_bit(flt, 1'h1, "no fault with error");
    cut = 2'h0;
    do_tick();
    chk_err(werr, 2'h1, "cleared while enabled");
    den = 1'h0;
    do_tick();
    chk_err(werr, 2'h0, "not cleared");
    chk_bit(flt, 1'h0, "fault stuck");
    mode = dsd_pkg::MODE_PAIR2;
    fuse = 1'h0;
    cut = 2'h2;
    repeat (3) do_tick();
    chk_err(werr, 2'h2, "second pair error");
    chk_bit(flt, 1'h0, "fault without use");
    cut = 2'h0;
    do_tick();
    chk_err(werr, 2'h0, "second pair not cleared");
    $display("t_plaus done");
  endtask

  // One configuration case, judged two clocks after it is applied.
  task automatic cfg_case(input logic [1:0] m, input logic p, input logic [9:0] s, input logic [7:0] c,
                          input logic exp);
    mode = m;
    plaus = p;
    qs = s;
    cms = c;
    clks(2);
    chk_bit(cerr, exp, "configuration flag");
  endtask
  task automatic t_cfg;
    cfg_case(dsd_pkg::MODE_SINGLE, 1'h0, 10'h00A, 8'h32, 1'h0);
    cfg_case(dsd_pkg::MODE_PAIR1, 1'h1, 10'h00A, 8'h32, 1'h0);
    cfg_case(dsd_pkg::MODE_PAIR2, 1'h1, 10'h3E8, 8'h32, 1'h0);
    cfg_case(dsd_pkg::MODE_SINGLE, 1'h1, 10'h00A, 8'h32, 1'h1);
    cfg_case(2'h3, 1'h0, 10'h00A, 8'h32, 1'h1);
    cfg_case(dsd_pkg::MODE_PAIR1, 1'h0, 10'h009, 8'h32, 1'h1);
    cfg_case(dsd_pkg::MODE_PAIR1, 1'h0, 10'h3E9, 8'h32, 1'h1);
    cfg_case(dsd_pkg::MODE_PAIR1, 1'h0, 10'h00A, 8'h64, 1'h1);
    $display("t_cfg done");
  endtask

  // Clock at 125 MHz.
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      test_done();
    end
  end

  // Main sequence; quiet time 100 ms covers the slowest coasting edge gap.
  initial begin
    {rstn, tick, den, plaus, fuse, step} = 6'h00;
    mode = dsd_pkg::MODE_SINGLE;
    cut = 2'h0;
    qs = 10'h00A;
    cms = 8'h32;
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'h1;
    clks(1);
    t_reset();
    t_stop();
    t_abort();
    t_plaus();
    t_cfg();
    test_done();
  end
endmodule
